// *** verilog/cgb_gates.sv ***
`timescale 1ns/1ns
`default_nettype none
// Gate library evaluated on each program-cycle strobe; outputs hold between strobes.
module cgb_gates
   import cgb_pkg::*;
(
   input  wire logic     clock_i,
   input  wire logic     sys_rst_i,
   input  wire logic     cycle_i,
   input  wire cgb_in_s  nand_in_i,
   input  wire cgb_in_s  enand_in_i,
   input  wire cgb_in_s  or_in_i,
   input  wire cgb_in_s  nor_in_i,
   input  wire cgb_in_s  xor_in_i,
   input  wire cgb_in_s  not_in_i,
   output var cgb_out_s  q_o
);
   logic [3:0] nand_c;
   logic [3:0] enand_c;
   logic [3:0] or_c;
   logic [3:0] nor_c;
   logic [3:0] xor_c;
   logic [3:0] not_c;
   logic [3:0] hist_r;
   cgb_out_s   q_r;
   cgb_out_s   q_nxt;
   logic       strb_seen_r;

   cgb_cond u_nand  (.in_i(nand_in_i),  .open_lvl_i(1'b1), .cond_o(nand_c));
   cgb_cond u_enand (.in_i(enand_in_i), .open_lvl_i(1'b1), .cond_o(enand_c));
   cgb_cond u_or    (.in_i(or_in_i),    .open_lvl_i(1'b0), .cond_o(or_c));
   cgb_cond u_nor   (.in_i(nor_in_i),   .open_lvl_i(1'b0), .cond_o(nor_c));
   cgb_cond u_xor   (.in_i(xor_in_i),   .open_lvl_i(1'b0), .cond_o(xor_c));
   cgb_cond u_not   (.in_i(not_in_i),   .open_lvl_i(1'b0), .cond_o(not_c));

   always_comb begin
      q_nxt         = q_r;
      q_nxt.nand_q  = ~(&nand_c);
      q_nxt.enand_q = (&hist_r) & ~(&enand_c);
      q_nxt.or_q    = |or_c;
      q_nxt.nor_q   = ~(|nor_c);
      q_nxt.xor_q   = xor_c[0] ^ xor_c[1];
      q_nxt.not_q   = ~not_c[0];
   end

   // History starts all low, so the first strobe can never see an all-high past.
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         hist_r <= CGB_HIST_RST;
      end else if (cycle_i) begin
         hist_r <= enand_c;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         q_r <= cgb_out_s'(CGB_OUT_RST);
      end else if (cycle_i) begin
         q_r <= q_nxt;
      end
   end

   assign q_o = q_r;

   // Only the first-evaluation check reads this flag; it takes no part in the gate behaviour.
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         strb_seen_r <= 1'h0;
      end else if (cycle_i) begin
         strb_seen_r <= 1'h1;
      end
   end

   // Plain gates: each strobe is judged at the next rising edge, from the raw pin fields where possible.
   chk_nand_value: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i |=> q_o.nand_q == ~(&$past(nand_c))
   ) else $error("nand output wrong");

   chk_nand_raw: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (nand_in_i.conn == 4'hF) && ((nand_in_i.level ^ nand_in_i.inv) != 4'hF) |=> q_o.nand_q
   ) else $error("nand low with a low pin");

   chk_nand_open: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (nand_in_i.conn == 4'h0) |=> !q_o.nand_q
   ) else $error("open nand not low");

   chk_or_value: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i |=> q_o.or_q == |$past(or_c)
   ) else $error("or output wrong");

   chk_or_raw: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (|(or_in_i.conn & (or_in_i.level ^ or_in_i.inv))) |=> q_o.or_q
   ) else $error("or low with a high pin");

   chk_or_open: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (or_in_i.conn == 4'h0) |=> !q_o.or_q
   ) else $error("open or not low");

   chk_open_low: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (nor_in_i.conn == 4'h0) |=> q_o.nor_q
   ) else $error("open nor not high");

   chk_nor_value: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (|nor_c) |=> !q_o.nor_q
   ) else $error("nor not low");

   chk_nor_raw: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (|(nor_in_i.conn & (nor_in_i.level ^ nor_in_i.inv))) |=> !q_o.nor_q
   ) else $error("nor high with a high pin");

   chk_nor_all_low: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && !(|nor_c) |=> q_o.nor_q
   ) else $error("nor low with all pins low");

   chk_xor_value: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i |=> q_o.xor_q == ($past(xor_c[0]) ^ $past(xor_c[1]))
   ) else $error("xor wrong");

   chk_xor_same: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (xor_c[0] == xor_c[1]) |=> !q_o.xor_q
   ) else $error("xor high with equal pins");

   chk_xor_open: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (xor_in_i.conn[1:0] == 2'h0) |=> !q_o.xor_q
   ) else $error("open xor not low");

   chk_not_value: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && not_in_i.conn[0] |=> q_o.not_q == ~($past(not_in_i.level[0]) ^ $past(not_in_i.inv[0]))
   ) else $error("not wrong");

   chk_not_open: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && !not_in_i.conn[0] |=> q_o.not_q
   ) else $error("open not input not read as low");

   // Edge NAND: a pulse needs an all-high history and a low pin now, and lasts one evaluation.
   chk_enand_pulse: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i |=> q_o.enand_q == ((&$past(hist_r)) & ~(&$past(enand_c)))
   ) else $error("edge nand wrong");

   chk_enand_rise: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (&hist_r) && !(&enand_c) |=> q_o.enand_q
   ) else $error("edge nand missed a pulse");

   chk_enand_no_past: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && !(&hist_r) |=> !q_o.enand_q
   ) else $error("edge nand pulsed without high history");

   chk_enand_steady: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (&enand_c) |=> !q_o.enand_q
   ) else $error("edge nand pulsed with all pins high");

   chk_enand_once: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && q_o.enand_q |=> !q_o.enand_q
   ) else $error("edge nand pulse lasted two evaluations");

   chk_enand_open: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (enand_in_i.conn == 4'h0) |=> !q_o.enand_q
   ) else $error("open edge nand pulsed");

   chk_enand_open_hist: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && (enand_in_i.conn == 4'h0) |=> hist_r == 4'hF
   ) else $error("open edge nand history not high");

   // Strobe and reset: nothing moves between strobes, and reset leaves no history behind.
   chk_hold_idle: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      !cycle_i |=> $stable(q_o)
   ) else $error("output moved without strobe");

   chk_hist_load: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i |=> hist_r == $past(enand_c)
   ) else $error("history not loaded on strobe");

   chk_hist_hold: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      !cycle_i |=> $stable(hist_r)
   ) else $error("history moved without strobe");

   chk_hist_reset: assert property (
      @(posedge clock_i)
      sys_rst_i |=> hist_r == CGB_HIST_RST
   ) else $error("history not cleared by reset");

   chk_out_reset: assert property (
      @(posedge clock_i)
      sys_rst_i |=> q_o == cgb_out_s'(CGB_OUT_RST)
   ) else $error("outputs not cleared by reset");

   chk_first_cycle: assert property (
      @(posedge clock_i)
      sys_rst_i |=> !q_o.enand_q
   ) else $error("pulse after reset");

   chk_first_strobe: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      cycle_i && !strb_seen_r |=> !q_o.enand_q
   ) else $error("first evaluation after reset pulsed");

   chk_release_quiet: assert property (
      @(posedge clock_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |=> !q_o.enand_q
   ) else $error("pulse at reset release");
endmodule : cgb_gates
`default_nettype wire

// *** inc/cgb_pkg.sv ***
// Notes on behaviour
// - The NAND output is low only when all four inputs are high, otherwise high.
// - The edge NAND pulses high for one cycle when some input is now low and all were high the cycle before.
// - An unconnected edge NAND input counts as high for the present condition, and for the previous one from the second strobe after reset.
// - The OR output is high when any of its four inputs is high, low only when all are low.
// - Unconnected OR, NOR and XOR inputs count as low.
// - The NOR output is high only when all inputs are low and goes low once any input is high.
// - The XOR has two inputs and is high when they differ.
// - The NOT drives the complement of its single input every cycle.
// - NOR and OR take four inputs with all sixteen combinations defined.
// - Each input of every gate can be inverted on its own before the gate function.
// - An unconnected plain NAND input counts as high.
package cgb_pkg;
   localparam int unsigned CGB_NIN = 4;
   localparam int unsigned CGB_NXOR = 2;
   localparam logic [3:0] CGB_HIST_RST = 4'h0;
   localparam logic [5:0] CGB_OUT_RST = 6'h00;

   typedef enum logic [2:0] {
      CGB_NAND  = 3'h0,
      CGB_ENAND = 3'h1,
      CGB_OR    = 3'h2,
      CGB_NOR   = 3'h3,
      CGB_XOR   = 3'h4,
      CGB_NOT   = 3'h5
   } cgb_kind_e;

   // Per-gate input group: levels, which pins are wired, which are inverted.
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] conn;
      logic [3:0] inv;
   } cgb_in_s;

   typedef struct packed {
      logic nand_q;
      logic enand_q;
      logic or_q;
      logic nor_q;
      logic xor_q;
      logic not_q;
   } cgb_out_s;
endpackage : cgb_pkg

// *** verilog/cgb_cond.sv ***
`timescale 1ns/1ns
`default_nettype none
// Applies per-pin inversion, then substitutes the default level for open pins.
module cgb_cond
   import cgb_pkg::*;
(
   input  wire cgb_in_s    in_i,
   input  wire logic       open_lvl_i,
   output logic [3:0]      cond_o
);
   genvar g;
   generate
      for (g = 0; g < CGB_NIN; g++) begin : g_pin
         assign cond_o[g] = in_i.conn[g] ? (in_i.level[g] ^ in_i.inv[g]) : open_lvl_i;
      end
   endgenerate
endmodule : cgb_cond
`default_nettype wire

// *** tb/cgb_src.sv ***
`timescale 1ns/1ns
`default_nettype none
// Program-cycle source. It moves the strobe on falling edges only, so a change of run_i
// reaches the block at the second rising edge after the bench makes it.
module cgb_src (
   input  wire logic clock_i,
   input  wire logic run_i,
   output logic      cycle_o = 1'b0
);
   always @(negedge clock_i) cycle_o <= run_i;
endmodule : cgb_src
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import cgb_pkg::*;
   logic     clock_i = 1'b0;
   logic     sys_rst_i = 1'b1;
   logic     run = 1'b1;
   logic     cyc;
   cgb_in_s  s = '0;
   cgb_out_s q;
   int       fails = 0;
   int       cmp_count = 0;
   always #2 clock_i = ~clock_i;
   cgb_src src (.clock_i(clock_i), .run_i(run), .cycle_o(cyc));
   cgb_gates uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cycle_i(cyc), .nand_in_i(s),
      .enand_in_i(s), .or_in_i(s), .nor_in_i(s), .xor_in_i(s), .not_in_i(s), .q_o(q));
   task automatic check(input cgb_out_s got, input cgb_out_s exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t q_o %b expected %b", $time, got, exp);
      end
   endtask : check
   // One input set is taken at the next rising edge and judged at the falling edge after it.
   task automatic step(input logic [11:0] v, input logic [5:0] e);
      s = v;
      @(negedge clock_i);
      check(q, e);
   endtask : step
   task automatic t_truth();
      logic [3:0] v;
      logic [3:0] p;
      p = CGB_HIST_RST;
      for (int i = 0; i <= 16; i++) begin
         v = i[3:0];
         step({v, 4'hF, 4'h0}, {~&v, p == 4'hF && v != 4'hF, |v, ~|v, ^v[1:0], ~v[0]});
         p = v;
      end
   endtask : t_truth
   task automatic t_open();
      step(12'h000, 6'b000101);
      step(12'h011, 6'b001010);
      step(12'h0FF, 6'h08);
      step(12'hEF0, 6'b111011);
   endtask : t_open
   // Without a strobe outputs and history hold whatever the pins do; the strobe follows run one full clock late.
   task automatic t_idle();
      run <= 1'b0;
      step(12'hFF0, 6'h08);
      step(12'hEF0, 6'h08);
      run <= 1'b1;
      step(12'hEF0, 6'h08);
      step(12'hEF0, 6'h3B);
   endtask : t_idle
   // A reset in mid-run must clear an all-high history, so no pulse follows release.
   task automatic t_reset();
      step(12'hFF0, 6'h08);
      sys_rst_i = 1'b1;
      step(12'hFF0, 6'h00);
      sys_rst_i = 1'b0;
      step(12'hEF0, 6'h2B);
   endtask : t_reset
   task automatic conclude();
      $display("cmp_count %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      #1000;
      fails++;
      conclude();
   end
   initial begin
      repeat (6) @(negedge clock_i);
      sys_rst_i = 1'b0;
      t_truth();
      t_open();
      t_idle();
      t_reset();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
